// ---- rtl/ita_top.sv ----
// Indirect access window onto the switch address, VLAN and statistics tables
`include "ita_params.svh"
// Summary of operation
// - Command register write launches one access when idle
// - Command bit 12: one reads, zero writes
// - Bits 11:10 pick static, VLAN, dynamic, counters
// - Bits 9:0 give the entry index
// - Top bit 7 busy during slow reads
// - Top bits 2:0 show data 66:64, read-only
// - Offset 0x028 holds data bits 47:32
// - Offset 0x02a holds data bits 63:48
// - Offset 0x02c holds data bits 15:0
// - Offset 0x02e holds data bits 31:16
module ita_top import ita_pkg::*; #(
	parameter int DEPTH = `ITA_TBL_DEPTH,
	parameter int READ_LAT = `ITA_READ_LAT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [`ITA_ADDR_W-1:0] reg_addr,
	input wire logic [`ITA_REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`ITA_REG_W-1:0] reg_rdata,
	output logic read_busy
);

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	ita_regs_t r, n;
	logic launch;
	logic launch_rd;
	logic launch_slow;
	ita_sel_t launch_sel;
	logic [`ITA_INDEX_W-1:0] launch_idx;
	logic [3:0] tbl_wr;
	logic [`ITA_DATA_W-1:0] tbl_q [0:3];
	logic slow_done;
	logic capture;
	logic [`ITA_DATA_W-1:0] cap_word;

	// Commands arriving while an access is open are dropped
	assign launch = reg_wr && (reg_addr == `ITA_OFF_CMD) && (r.st == ST_IDLE);
	assign launch_rd = reg_wdata[`ITA_CMD_DIR_BIT];
	assign launch_sel = ita_sel_t'(reg_wdata[`ITA_CMD_SEL_HI:`ITA_CMD_SEL_LO]);
	assign launch_idx = reg_wdata[`ITA_CMD_IDX_HI:0];
	assign launch_slow = launch && launch_rd && ((launch_sel == SEL_DYN) || (launch_sel == SEL_CNT));

	// ------------------------------------------------------------------------
	// Table stores
	// ------------------------------------------------------------------------
	always_comb begin
		tbl_wr = 4'h0;
		if (launch && !launch_rd) begin
			tbl_wr[launch_sel] = 1'b1;
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_tbl
		ita_tbl_ram #(
			.W(`ITA_DATA_W),
			.DEPTH(DEPTH),
			.AW(`ITA_INDEX_W)
		) u_tbl (
			.core_clk(core_clk),
			.rst(rst),
			.wr_en(tbl_wr[g]),
			.wr_addr(launch_idx),
			.wr_data(r.win),
			.rd_addr(r.cmd[`ITA_CMD_IDX_HI:0]),
			.rd_data(tbl_q[g])
		);
	end

	ita_busy_tmr #(
		.LAT(READ_LAT)
	) u_tmr (
		.core_clk(core_clk),
		.rst(rst),
		.start(launch_slow),
		.done(slow_done)
	);

	assign cap_word = tbl_q[r.cmd[`ITA_CMD_SEL_HI:`ITA_CMD_SEL_LO]];
	// Fast tables answer straight away, slow ones after the timer
	assign capture = (r.st == ST_WAIT) && (!r.cmd[`ITA_CMD_SEL_HI] || slow_done);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		n = r;
		n.rdata = '0;

		// Host writes to the data window
		if (reg_wr) begin
			unique case (reg_addr)
				`ITA_OFF_D47_32: n.win[47:32] = reg_wdata;
				`ITA_OFF_D63_48: n.win[63:48] = reg_wdata;
				`ITA_OFF_D15_0: n.win[15:0] = reg_wdata;
				`ITA_OFF_D31_16: n.win[31:16] = reg_wdata;
				default: begin
				end
			endcase
		end

		// Sequencer
		unique case (r.st)
			ST_IDLE: begin
				if (launch) begin
					n.cmd = reg_wdata;
					if (launch_rd) begin
						n.st = ST_FETCH;
						n.busy = launch_slow;
					end
				end
			end
			ST_FETCH: begin
				n.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (capture) begin
					n.win = cap_word;
					n.busy = 1'b0;
					n.st = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// Register reads, answered in the following cycle
		if (reg_rd) begin
			unique case (reg_addr)
				`ITA_OFF_TOP: begin
					n.rdata[`ITA_TOP_BUSY_BIT] = r.busy;
					n.rdata[`ITA_TOP_DATA_HI:0] = r.win[66:64];
				end
				`ITA_OFF_D47_32: n.rdata = r.win[47:32];
				`ITA_OFF_D63_48: n.rdata = r.win[63:48];
				`ITA_OFF_D15_0: n.rdata = r.win[15:0];
				`ITA_OFF_D31_16: n.rdata = r.win[31:16];
				`ITA_OFF_CMD: n.rdata = r.cmd;
				default: n.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r.st <= ST_IDLE;
			r.cmd <= `ITA_CMD_RST;
			r.win <= `ITA_WIN_RST;
			r.busy <= 1'b0;
			r.rdata <= '0;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata = r.rdata;
	assign read_busy = r.busy;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Cycles spent busy, bounds the slow read
	logic [8:0] busy_cnt;

	always_ff @(posedge core_clk) begin
		if (rst || !r.busy) begin
			busy_cnt <= 9'h000;
		end else begin
			busy_cnt <= busy_cnt + 9'h001;
		end
	end

	sequence fast_rd_launch;
		launch && launch_rd && !reg_wdata[`ITA_CMD_SEL_HI];
	endsequence

	sequence slow_rd_launch;
		launch && launch_rd && reg_wdata[`ITA_CMD_SEL_HI];
	endsequence

	sequence back_idle;
		(r.st == ST_IDLE) && !r.busy;
	endsequence

	sequence slow_pending;
		r.busy && (r.st != ST_IDLE);
	endsequence

	// Longest launch-to-idle span of a slow read
	localparam int SLOW_SPAN = READ_LAT + 2;

	cmd_capture_a: assert property (
		launch |=> (r.cmd == $past(reg_wdata)) && ((r.st == ST_FETCH) == $past(launch_rd)))
		else $error("command not taken on control write");

	dir_write_a: assert property (
		(tbl_wr != 4'h0) == (launch && !reg_wdata[`ITA_CMD_DIR_BIT]))
		else $error("table write enable does not follow direction bit");

	table_pick_a: assert property (
		(launch && !launch_rd) |-> (tbl_wr == (4'h1 << reg_wdata[`ITA_CMD_SEL_HI:`ITA_CMD_SEL_LO])))
		else $error("wrong table written");

	index_hold_a: assert property (
		(r.st != ST_IDLE) |=> $stable(r.cmd[`ITA_CMD_IDX_HI:0]))
		else $error("index changed during access");

	busy_rise_a: assert property (
		slow_rd_launch |=> r.busy [*2])
		else $error("busy not raised for slow read");

	busy_bound_a: assert property (
		busy_cnt <= 9'(READ_LAT + 2))
		else $error("slow read held busy too long");

	fast_done_a: assert property (
		fast_rd_launch |=> !r.busy ##2 back_idle)
		else $error("fast read did not finish in two cycles");

	top_field_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_TOP) |=>
			(reg_rdata == {8'h00, $past(r.busy), 4'h0, $past(r.win[66:64])}))
		else $error("top register read wrong");

	top_ro_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_TOP && !capture) |=> $stable(r.win[66:64]))
		else $error("top data bits changed by host write");

	win_47_32_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_D47_32 && !capture) |=> (r.win[47:32] == $past(reg_wdata)))
		else $error("window bits 47:32 not written");

	win_63_48_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_D63_48 && !capture) |=> (r.win[63:48] == $past(reg_wdata)))
		else $error("window bits 63:48 not written");

	win_15_0_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_D15_0 && !capture) |=> (r.win[15:0] == $past(reg_wdata)))
		else $error("window bits 15:0 not written");

	win_31_16_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_D31_16 && !capture) |=> (r.win[31:16] == $past(reg_wdata)))
		else $error("window bits 31:16 not written");

	read_fill_a: assert property (
		capture |=> ((r.win == $past(cap_word)) and back_idle))
		else $error("read result not loaded into window");

	readback_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_D47_32) |=> (reg_rdata == $past(r.win[47:32])))
		else $error("read data of bits 47:32 wrong");

	// ------------------------------------------------------------------------
	// Register readback, sequencer and timing checks
	// ------------------------------------------------------------------------

	readback_63_48_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_D63_48) |=> (reg_rdata == $past(r.win[63:48])))
		else $error("read data of bits 63:48 wrong");

	readback_15_0_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_D15_0) |=> (reg_rdata == $past(r.win[15:0])))
		else $error("read data of bits 15:0 wrong");

	readback_31_16_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_D31_16) |=> (reg_rdata == $past(r.win[31:16])))
		else $error("read data of bits 31:16 wrong");

	cmd_readback_a: assert property (
		(reg_rd && reg_addr == `ITA_OFF_CMD) |=> (reg_rdata == $past(r.cmd)))
		else $error("command read back wrong");

	rdata_idle_a: assert property (
		!reg_rd |=> (reg_rdata == 16'h0000))
		else $error("read data not zero outside a read");

	cmd_drop_a: assert property (
		(reg_wr && reg_addr == `ITA_OFF_CMD && r.st != ST_IDLE) |=> $stable(r.cmd))
		else $error("command taken while access open");

	write_idle_a: assert property (
		(launch && !launch_rd) |=> (r.st == ST_IDLE) && !r.busy)
		else $error("table write left sequencer busy");

	counter_slow_a: assert property (
		(launch && launch_rd && (launch_sel == SEL_CNT)) |=> r.busy)
		else $error("counter read not treated as slow");

	busy_only_slow_a: assert property (
		$rose(r.busy) |-> $past(launch_slow))
		else $error("busy raised without slow read");

	busy_fall_a: assert property (
		$fell(r.busy) |-> $past(capture))
		else $error("busy cleared without read completion");

	busy_state_a: assert property (
		r.busy |-> (r.st != ST_IDLE))
		else $error("busy set while sequencer idle");

	busy_fast_a: assert property (
		((r.st != ST_IDLE) && !r.cmd[`ITA_CMD_SEL_HI]) |-> !r.busy)
		else $error("busy set during fast read");

	slow_timer_a: assert property (
		slow_rd_launch |=> !slow_done [*2])
		else $error("slow read timer ended too early");

	timer_done_a: assert property (
		slow_done |-> (r.st == ST_WAIT) && r.busy)
		else $error("timer ended outside a slow read");

	slow_fill_a: assert property (
		slow_rd_launch |=> slow_pending ##[1:SLOW_SPAN] back_idle)
		else $error("slow read did not complete in time");

	wait_hold_a: assert property (
		(r.st == ST_WAIT && !capture) |=> (r.st == ST_WAIT))
		else $error("sequencer left wait without result");

	fetch_next_a: assert property (
		(r.st == ST_FETCH) |=> (r.st == ST_WAIT))
		else $error("fetch not followed by wait");

	fast_fill_a: assert property (
		(r.st == ST_WAIT && !r.cmd[`ITA_CMD_SEL_HI]) |=> (r.st == ST_IDLE))
		else $error("fast read not finished after wait");

	win_hold_a: assert property (
		(!reg_wr && !capture) |=> $stable(r.win))
		else $error("window changed without write or read");

endmodule

// ---- rtl/ita_params.svh ----
// Register offsets, field positions, reset values and counts of the indirect table access port
`ifndef ITA_PARAMS_SVH
`define ITA_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ITA_OFF_TOP 8'h26
`define ITA_OFF_D47_32 8'h28
`define ITA_OFF_D63_48 8'h2a
`define ITA_OFF_D15_0 8'h2c
`define ITA_OFF_D31_16 8'h2e
`define ITA_OFF_CMD 8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ITA_CMD_DIR_BIT 12
`define ITA_CMD_SEL_HI 11
`define ITA_CMD_SEL_LO 10
`define ITA_CMD_IDX_HI 9
`define ITA_TOP_BUSY_BIT 7
`define ITA_TOP_DATA_HI 2

// ----------------------------------------------------------------------------
// Widths, reset values and counts
// ----------------------------------------------------------------------------
`define ITA_ADDR_W 8
`define ITA_REG_W 16
`define ITA_DATA_W 67
`define ITA_INDEX_W 10
`define ITA_TBL_DEPTH 1024
`define ITA_READ_LAT 4
`define ITA_CMD_RST 16'h0000
`define ITA_WIN_RST 67'h0

`endif

// ---- rtl/ita_pkg.sv ----
// Types shared by the indirect table access port
package ita_pkg;

`include "ita_params.svh"

	// ------------------------------------------------------------------------
	// Sequencer states and table selection
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WAIT
	} ita_state_t;

	typedef enum logic [1:0] {
		SEL_STATIC = 2'h0,
		SEL_VLAN = 2'h1,
		SEL_DYN = 2'h2,
		SEL_CNT = 2'h3
	} ita_sel_t;

	// ------------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------------
	typedef struct packed {
		ita_state_t st;
		logic [`ITA_REG_W-1:0] cmd;
		logic [`ITA_DATA_W-1:0] win;
		logic busy;
		logic [`ITA_REG_W-1:0] rdata;
	} ita_regs_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic run;
		logic done;
	} ita_tmr_t;

endpackage

// ---- rtl/ita_tbl_ram.sv ----
// One table store with synchronous write and registered read
`include "ita_params.svh"
module ita_tbl_ram import ita_pkg::*; #(
	parameter int W = `ITA_DATA_W,
	parameter int DEPTH = `ITA_TBL_DEPTH,
	parameter int AW = `ITA_INDEX_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);

	logic [W-1:0] mem [0:DEPTH-1];

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// ---- rtl/ita_busy_tmr.sv ----
// Access time of the slow tables: one pulse LAT + 1 cycles after start
`include "ita_params.svh"
module ita_busy_tmr import ita_pkg::*; #(
	parameter int LAT = `ITA_READ_LAT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);

	ita_tmr_t r, n;

	always_comb begin
		n = r;
		n.done = 1'b0;
		if (start) begin
			n.run = 1'b1;
			n.cnt = 8'h01;
		end else if (r.run) begin
			if (r.cnt == 8'(LAT)) begin
				n.run = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign done = r.done;

endmodule

// ---- tb/indirect_table_access_tb.sv ----
// Self-checking bench of the indirect table access port
`include "ita_params.svh"

module indirect_table_access_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------------
	// Stimulus and design
	// ------------------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [`ITA_ADDR_W-1:0] reg_addr = '0;
	logic [`ITA_REG_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [`ITA_REG_W-1:0] reg_rdata;
	logic read_busy;
	int bad_count = 0;
	int checked = 0;
	logic [7:0] offs [4] = '{`ITA_OFF_D15_0, `ITA_OFF_D31_16, `ITA_OFF_D47_32, `ITA_OFF_D63_48};

	always #50 core_clk = ~core_clk;

	ita_top #(.DEPTH(`ITA_TBL_DEPTH), .READ_LAT(`ITA_READ_LAT)) uut (
		.core_clk(core_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.read_busy(read_busy)
	);

	// ------------------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] got;
		rd(a, got);
		chk(name, exp, got);
	endtask

	// Busy level one cycle after launch, then poll the top register
	task automatic wait_idle(input logic slow);
		logic [15:0] s;
		int n;
		n = 0;
		@(posedge core_clk);
		#1;
		chk("read_busy level", {15'h0, slow}, {15'h0, read_busy});
		rd(`ITA_OFF_TOP, s);
		chk("busy first poll", {8'h00, slow, 7'h00}, s);
		while (s[`ITA_TOP_BUSY_BIT] !== 1'b0 && n < 20) begin
			rd(`ITA_OFF_TOP, s);
			n++;
		end
		chk("busy cleared", 16'h0000, s);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 100);
		bad_count++;
		print_verdict();
	end

	// ------------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++) rdchk("window reset", offs[k], 16'h0000);
		rdchk("top reset", `ITA_OFF_TOP, 16'h0000);
		rdchk("command reset", `ITA_OFF_CMD, 16'h0000);
		// Window read back, unmapped and read-only places
		for (int k = 0; k < 4; k++) wr(offs[k], {12'hc3a, k[3:0]});
		wr(8'h40, 16'hffff);
		wr(`ITA_OFF_TOP, 16'hffff);
		for (int k = 0; k < 4; k++) rdchk("window rw", offs[k], {12'hc3a, k[3:0]});
		@(posedge core_clk);
		#1;
		chk("rdata idle", 16'h0000, reg_rdata);
		rdchk("unmapped", 8'h40, 16'h0000);
		rdchk("top read-only", `ITA_OFF_TOP, 16'h0000);
		// Distinct entry in every table at the top index
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 4; k++) wr(offs[k], {s[1:0], k[1:0], 12'h5a3});
			wr(`ITA_OFF_CMD, {3'h0, 1'b0, s[1:0], 10'h3ff});
		end
		rdchk("command readback", `ITA_OFF_CMD, 16'h0fff);
		for (int k = 0; k < 4; k++) wr(offs[k], 16'h0000);
		wr(`ITA_OFF_CMD, 16'h0000);
		// Read every table back into the window
		for (int s = 0; s < 4; s++) begin
			wr(`ITA_OFF_CMD, {3'h0, 1'b1, s[1:0], 10'h3ff});
			wait_idle(s[1]);
			for (int k = 0; k < 4; k++) rdchk("table entry", offs[k], {s[1:0], k[1:0], 12'h5a3});
			rdchk("top bits", `ITA_OFF_TOP, 16'h0000);
		end
		wr(`ITA_OFF_CMD, 16'h1000);
		wait_idle(1'b0);
		for (int k = 0; k < 4; k++) rdchk("index zero entry", offs[k], 16'h0000);
		// Command during an open slow read is dropped
		wr(`ITA_OFF_CMD, 16'h1bff);
		wr(`ITA_OFF_CMD, 16'h0000);
		rdchk("dropped command", `ITA_OFF_CMD, 16'h1bff);
		rdchk("busy done", `ITA_OFF_TOP, 16'h0000);
		rdchk("dynamic entry", `ITA_OFF_D15_0, 16'h85a3);
		print_verdict();
	end
endmodule
